// ---- logic/long_reset_timer.sv ----
`timescale 1ns/1ps
// ==========================================================
// times the long bus reset once launched
module long_reset_timer #(
    parameter int unsigned CYCLES = phy_regs_pkg::LONG_RESET_CYCLES
) (
    // clock and reset
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    input  wire logic     ce_in,
    // control side
    long_reset_if.timer   lr
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef enum logic [0:0] {
        T_IDLE = 1'b0,
        T_RUN  = 1'b1
    } tstate_t;

    typedef struct packed {
        tstate_t       fsm;
        logic [CW-1:0] cnt;
        logic          done;
    } timer_t;

    timer_t t_reg;
    timer_t t_next;

    // busy for exactly CYCLES clocks after a launch
    always_comb begin
        t_next      = t_reg;
        t_next.done = 1'b0;
        case (t_reg.fsm)
            T_IDLE: begin
                if (lr.start) begin
                    t_next.fsm = T_RUN;
                    t_next.cnt = CW'(CYCLES - 1);
                end
            end
            T_RUN: begin
                if (t_reg.cnt == '0) begin
                    t_next.fsm  = T_IDLE;
                    t_next.done = 1'b1;
                end else begin
                    t_next.cnt = t_reg.cnt - 1'b1;
                end
            end
            default: begin
                t_next.fsm = T_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            t_reg <= '{fsm: T_IDLE, cnt: '0, done: 1'b0};
        end else if (ce_in) begin
            t_reg <= t_next;
        end
    end

    assign lr.busy = (t_reg.fsm == T_RUN);
    assign lr.done = t_reg.done;
endmodule

// ---- logic/phy_base_regs.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - sixteen addresses: 0h-7h are fixed base registers, 8h-Fh show one of eight pages.
// - the page shown on the upper eight addresses comes from the page field of base register 7h.
// - base register fields sit at the same place and mean the same whatever page is chosen.
// - reserved registers and fields read zero, and all of pages 2 to 6 is reserved.
// - the 6-bit node address is read-only, loaded at self-identification end, invalid after a bus reset.
// - the read-only root flag clears on every bus reset and sets when this node wins tree identification.
// - the read-only cable power bit follows the synchronised cable power sense pin.
// - the root holdoff bit is writable, cleared by system reset, kept across bus resets.
// - the long-reset request starts a 166 us bus reset once no receive or transmit is running.
// - the long-reset request clears on system reset and on any bus reset.
// - the 6-bit gap count loads from a register write or from a phy configuration packet.
// - the gap count returns to 3Fh on system reset and after two bus resets with no load between.
// - base register 2 reads extended code 111b and a port total of 0010b.
// - base register 3 reads top speed 010b and repeater delay 0000b.
module phy_base_regs #(
    parameter int unsigned LRST_CYCLES = phy_regs_pkg::LONG_RESET_CYCLES
) (
    // clock, reset, enable
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // events from the phy core
    input  wire logic       bus_reset_in,
    input  wire logic       selfid_done_in,
    input  wire logic [5:0] phys_id_in,
    input  wire logic       root_won_in,
    input  wire logic       link_idle_in,
    input  wire logic       phy_cfg_gap_valid_in,
    input  wire logic [5:0] phy_cfg_gap_in,
    // cable power sense pin
    input  wire logic       cable_power_pin_in,
    // state toward the phy core
    output logic      [5:0] node_phys_addr_out,
    output logic            node_id_valid_out,
    output logic            root_out,
    output logic            cable_power_state_out,
    output logic            root_holdoff_out,
    output logic      [5:0] gap_count_out,
    output logic            long_reset_start_out,
    output logic            long_reset_active_out,
    // interrupt
    output logic            irq_out
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]                        rdata;
        logic [phy_regs_pkg::NODE_ID_W-1:0] node_phys_addr;
        logic                              node_valid;
        logic                              root;
        logic                              root_holdoff;
        logic                              long_reset_request;
        logic [phy_regs_pkg::GAP_W-1:0]     gap;
        logic                              gap_armed;
        logic [phy_regs_pkg::PAGE_W-1:0]    page;
        logic [phy_regs_pkg::PORT_SEL_W-1:0] port_sel;
        logic                              lrst_start;
        logic                              cps_prev;
        logic [phy_regs_pkg::IRQ_W-1:0]     irq_status;
        logic [phy_regs_pkg::IRQ_W-1:0]     irq_mask;
        logic                              irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        rdata:              phy_regs_pkg::RDATA_ZERO,
        node_phys_addr:     '0,
        node_valid:         1'b0,
        root:               1'b0,
        root_holdoff:       1'b0,
        long_reset_request: 1'b0,
        gap:                phy_regs_pkg::GAP_COUNT_RESET,
        gap_armed:          1'b0,
        page:               '0,
        port_sel:           '0,
        lrst_start:         1'b0,
        cps_prev:           1'b0,
        irq_status:         '0,
        irq_mask:           '0,
        irq:                1'b0
    };

    state_t st_reg;
    state_t st_next;

    logic   cps_level;
    logic   bus_reset_ev;
    logic   gap_wr;
    logic   ctl_wr;
    logic   page_wr;
    logic   status_wr;
    logic   mask_wr;
    logic   in_irq_page;

    long_reset_if lr ();

    // ==========================================================
    // submodules
    pin_sync u_cps_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .pin_in    (cable_power_pin_in),
        .level_out (cps_level)
    );

    long_reset_timer #(
        .CYCLES (LRST_CYCLES)
    ) u_lrst_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .lr     (lr.timer)
    );

    // ==========================================================
    // write decode
    assign in_irq_page  = (st_reg.page == phy_regs_pkg::IRQ_PAGE);
    assign ctl_wr       = wr_in && (addr_in == phy_regs_pkg::ADDR_ROOT_GAP);
    assign gap_wr       = ctl_wr;
    assign page_wr      = wr_in && (addr_in == phy_regs_pkg::ADDR_PAGE_SEL);
    assign status_wr    = wr_in && in_irq_page && (addr_in == phy_regs_pkg::ADDR_IRQ_STATUS);
    assign mask_wr      = wr_in && in_irq_page && (addr_in == phy_regs_pkg::ADDR_IRQ_MASK);
    // our own long reset launch counts as a bus reset too
    assign bus_reset_ev = bus_reset_in || st_reg.lrst_start;
    assign lr.start     = st_reg.lrst_start;

    // ==========================================================
    // next state
    always_comb begin
        logic [7:0]                    rd_byte;
        logic [phy_regs_pkg::IRQ_W-1:0] ev;
        rd_byte = phy_regs_pkg::RDATA_ZERO;
        ev      = '0;
        st_next = st_reg;
        st_next.lrst_start = 1'b0;

        // writable control bits; read-only fields never load from the bus
        if (ctl_wr) begin
            st_next.root_holdoff       = wdata_in[phy_regs_pkg::HOLDOFF_BIT];
            st_next.long_reset_request = wdata_in[phy_regs_pkg::LRST_BIT];
        end
        if (page_wr) begin
            st_next.page     = wdata_in[phy_regs_pkg::PAGE_LSB +: phy_regs_pkg::PAGE_W];
            st_next.port_sel = wdata_in[phy_regs_pkg::PORT_SEL_LSB +: phy_regs_pkg::PORT_SEL_W];
        end

        // self-identification and tree identification results
        if (selfid_done_in) begin
            st_next.node_phys_addr = phys_id_in;
            st_next.node_valid     = 1'b1;
        end
        if (root_won_in) begin
            st_next.root = 1'b1;
        end

        // bus reset wins over the results above
        if (bus_reset_ev) begin
            st_next.root               = 1'b0;
            st_next.node_valid         = 1'b0;
            st_next.long_reset_request = 1'b0;
            if (st_reg.gap_armed) begin
                st_next.gap = phy_regs_pkg::GAP_COUNT_RESET;
            end
            st_next.gap_armed = 1'b1;
        end

        // gap loads disarm the two-reset default, register write last
        if (phy_cfg_gap_valid_in) begin
            st_next.gap       = phy_cfg_gap_in;
            st_next.gap_armed = 1'b0;
        end
        if (gap_wr) begin
            st_next.gap       = wdata_in[phy_regs_pkg::GAP_LSB +: phy_regs_pkg::GAP_W];
            st_next.gap_armed = 1'b0;
        end

        // launch the long reset once the wire is quiet
        if (st_reg.long_reset_request && link_idle_in && !lr.busy && !st_reg.lrst_start) begin
            st_next.lrst_start = 1'b1;
        end

        // interrupt events, set wins over write-one-to-clear
        ev[phy_regs_pkg::IRQ_SELFID]    = selfid_done_in;
        ev[phy_regs_pkg::IRQ_CPS_LOST]  = st_reg.cps_prev && !cps_level;
        ev[phy_regs_pkg::IRQ_BUS_RESET] = bus_reset_ev;
        ev[phy_regs_pkg::IRQ_LRST_DONE] = lr.done;
        if (status_wr) begin
            st_next.irq_status = st_next.irq_status & ~wdata_in[phy_regs_pkg::IRQ_W-1:0];
        end
        st_next.irq_status = st_next.irq_status | ev;
        if (mask_wr) begin
            st_next.irq_mask = wdata_in[phy_regs_pkg::IRQ_W-1:0];
        end
        st_next.irq      = |(st_next.irq_status & st_next.irq_mask);
        st_next.cps_prev = cps_level;

        // read mux, base registers ignore the page
        if (!addr_in[phy_regs_pkg::PAGED_BIT]) begin
            case (addr_in)
                phy_regs_pkg::ADDR_NODE_ID: begin
                    rd_byte[phy_regs_pkg::NODE_ID_LSB +: phy_regs_pkg::NODE_ID_W] = st_reg.node_phys_addr;
                    rd_byte[phy_regs_pkg::ROOT_BIT] = st_reg.root;
                    rd_byte[phy_regs_pkg::CPS_BIT]  = cps_level;
                end
                phy_regs_pkg::ADDR_ROOT_GAP: begin
                    rd_byte[phy_regs_pkg::HOLDOFF_BIT] = st_reg.root_holdoff;
                    rd_byte[phy_regs_pkg::LRST_BIT]    = st_reg.long_reset_request;
                    rd_byte[phy_regs_pkg::GAP_LSB +: phy_regs_pkg::GAP_W] = st_reg.gap;
                end
                phy_regs_pkg::ADDR_EXT_PORTS: begin
                    rd_byte[phy_regs_pkg::EXT_LSB +: 3]   = phy_regs_pkg::EXTENDED_CODE;
                    rd_byte[phy_regs_pkg::PORTS_LSB +: 4] = phy_regs_pkg::TOTAL_PORTS;
                end
                phy_regs_pkg::ADDR_SPEED: begin
                    rd_byte[phy_regs_pkg::SPEED_LSB +: 3] = phy_regs_pkg::MAX_SPEED;
                    rd_byte[phy_regs_pkg::DELAY_LSB +: 4] = phy_regs_pkg::REPEATER_DELAY;
                end
                phy_regs_pkg::ADDR_PAGE_SEL: begin
                    rd_byte[phy_regs_pkg::PAGE_LSB +: phy_regs_pkg::PAGE_W]         = st_reg.page;
                    rd_byte[phy_regs_pkg::PORT_SEL_LSB +: phy_regs_pkg::PORT_SEL_W] = st_reg.port_sel;
                end
                default: begin
                    rd_byte = phy_regs_pkg::RDATA_ZERO;
                end
            endcase
        end else if (in_irq_page) begin
            case (addr_in)
                phy_regs_pkg::ADDR_IRQ_STATUS: begin
                    rd_byte[phy_regs_pkg::IRQ_W-1:0] = st_reg.irq_status;
                end
                phy_regs_pkg::ADDR_IRQ_MASK: begin
                    rd_byte[phy_regs_pkg::IRQ_W-1:0] = st_reg.irq_mask;
                end
                default: begin
                    rd_byte = phy_regs_pkg::RDATA_ZERO;
                end
            endcase
        end else begin
            rd_byte = phy_regs_pkg::RDATA_ZERO;
        end

        // read data stands only in the cycle after the strobe
        st_next.rdata = rd_in ? rd_byte : phy_regs_pkg::RDATA_ZERO;
    end

    // ==========================================================
    // state register, frozen while the enable is low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= STATE_RESET;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign rdata_out             = st_reg.rdata;
    assign node_phys_addr_out    = st_reg.node_phys_addr;
    assign node_id_valid_out     = st_reg.node_valid;
    assign root_out              = st_reg.root;
    assign cable_power_state_out = cps_level;
    assign root_holdoff_out      = st_reg.root_holdoff;
    assign gap_count_out         = st_reg.gap;
    assign long_reset_start_out  = st_reg.lrst_start;
    assign long_reset_active_out = lr.busy;
    assign irq_out               = st_reg.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_page_field_load: assert property (ce_in && page_wr |=>
        st_reg.page == $past(wdata_in[7:5]))
        else $error("page field did not load");

    a_reserved_pages: assert property (ce_in && rd_in && addr_in[3] && st_reg.page >= 3'h2 && st_reg.page <= 3'h6
        |=> rdata_out == 8'h00)
        else $error("reserved page read not zero");

    a_reserved_six: assert property (ce_in && rd_in && addr_in == 4'h6 |=> rdata_out == 8'h00)
        else $error("reserved base register read not zero");

    a_ext_ports_code: assert property (ce_in && rd_in && addr_in == 4'h2 |=> rdata_out == 8'he2)
        else $error("extended and port code wrong");

    a_speed_code: assert property (ce_in && rd_in && addr_in == 4'h3 |=> rdata_out == 8'h40)
        else $error("speed and delay code wrong");

    a_node_id_load: assert property (ce_in && selfid_done_in && !bus_reset_ev |=>
        node_phys_addr_out == $past(phys_id_in) && node_id_valid_out)
        else $error("node address not loaded");

    a_root_clear: assert property (ce_in && bus_reset_ev |=> !root_out && !node_id_valid_out)
        else $error("root flag survived bus reset");

    a_cps_follow: assert property ((ce_in && cable_power_pin_in)[*5] |=> cable_power_state_out)
        else $error("cable power bit did not follow pin");

    a_holdoff_kept: assert property (ce_in && bus_reset_in && !ctl_wr |=>
        $stable(root_holdoff_out))
        else $error("root holdoff changed on bus reset");

    a_lrst_quiet: assert property ($rose(long_reset_start_out) |->
        $past(link_idle_in) && $past(st_reg.long_reset_request) && !long_reset_active_out)
        else $error("long reset launched while busy");

    a_lrst_clear: assert property (ce_in && bus_reset_in |=> !st_reg.long_reset_request)
        else $error("long reset request survived bus reset");

    a_gap_write: assert property (ce_in && gap_wr |=> gap_count_out == $past(wdata_in[5:0]))
        else $error("gap count write lost");

    a_gap_default: assert property (ce_in && bus_reset_ev && st_reg.gap_armed && !gap_wr && !phy_cfg_gap_valid_in
        |=> gap_count_out == 6'h3f)
        else $error("gap count not restored");

    a_ro_ignored: assert property (ce_in && wr_in && addr_in == 4'h0 && !selfid_done_in && !bus_reset_ev
        |=> $stable(node_phys_addr_out))
        else $error("read-only field took a write");

    a_rdata_idle: assert property (ce_in && !rd_in |=> rdata_out == 8'h00)
        else $error("read data stood past its cycle");

    a_freeze_hold: assert property (!ce_in |=> $stable(st_reg))
        else $error("state moved while enable was low");

    c_long_reset: cover property ($rose(long_reset_start_out) ##1 long_reset_active_out);
    c_freeze: cover property (!ce_in ##1 ce_in);
    c_gap_default: cover property (bus_reset_ev && st_reg.gap_armed && gap_count_out != 6'h3f);
    c_irq_raised: cover property ($rose(irq_out));
    c_root_won: cover property (ce_in && root_won_in ##1 root_out);
endmodule

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
// ==========================================================
// three-stage pin synchroniser, level moves when stages 2 and 3 agree
module pin_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // pin and clean level
    input  wire logic pin_in,
    output logic      level_out
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    // shift chain, first stage read only by the second
    always_comb begin
        s_next     = s_reg;
        s_next.ff1 = pin_in;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        if (s_reg.ff2 == s_reg.ff3) begin
            s_next.level = s_reg.ff3;
        end
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '0;
        end else if (ce_in) begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.level;
endmodule

// ---- pkg/long_reset_if.sv ----
`timescale 1ns/1ps
// ==========================================================
// launch and progress of a long bus reset
interface long_reset_if;
    logic start;  // one-cycle launch
    logic busy;   // long reset on the wire
    logic done;   // one-cycle end marker
    modport ctrl  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

// ---- pkg/phy_regs_pkg.sv ----
// ==========================================================
// shared constants of the phy base register space
package phy_regs_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS     = 20;
    localparam int unsigned LONG_RESET_NS     = 166000;  // 166 us
    localparam int unsigned LONG_RESET_CYCLES = (LONG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // register addresses
    localparam logic [3:0] ADDR_NODE_ID    = 4'h0;
    localparam logic [3:0] ADDR_ROOT_GAP   = 4'h1;
    localparam logic [3:0] ADDR_EXT_PORTS  = 4'h2;
    localparam logic [3:0] ADDR_SPEED      = 4'h3;
    localparam logic [3:0] ADDR_LINK_PWR   = 4'h4;
    localparam logic [3:0] ADDR_EVENT_EN   = 4'h5;
    localparam logic [3:0] ADDR_RSVD_SIX   = 4'h6;
    localparam logic [3:0] ADDR_PAGE_SEL   = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h9;
    localparam logic [2:0] IRQ_PAGE        = 3'h7;
    localparam int         PAGED_BIT       = 3;
    // field positions and widths
    localparam int NODE_ID_LSB  = 2;
    localparam int NODE_ID_W    = 6;
    localparam int ROOT_BIT     = 1;
    localparam int CPS_BIT      = 0;
    localparam int HOLDOFF_BIT  = 7;
    localparam int LRST_BIT     = 6;
    localparam int GAP_LSB      = 0;
    localparam int GAP_W        = 6;
    localparam int EXT_LSB      = 5;
    localparam int PORTS_LSB    = 0;
    localparam int SPEED_LSB    = 5;
    localparam int DELAY_LSB    = 0;
    localparam int PAGE_LSB     = 5;
    localparam int PAGE_W       = 3;
    localparam int PORT_SEL_LSB = 0;
    localparam int PORT_SEL_W   = 4;
    // interrupt bits
    localparam int IRQ_W         = 4;
    localparam int IRQ_SELFID    = 0;
    localparam int IRQ_CPS_LOST  = 1;
    localparam int IRQ_BUS_RESET = 2;
    localparam int IRQ_LRST_DONE = 3;
    // fixed values
    localparam logic [5:0] GAP_COUNT_RESET = 6'h3f;
    localparam logic [2:0] EXTENDED_CODE   = 3'h7;
    localparam logic [3:0] TOTAL_PORTS     = 4'h2;
    localparam logic [2:0] MAX_SPEED       = 3'h2;
    localparam logic [3:0] REPEATER_DELAY  = 4'h0;
    localparam logic [7:0] RDATA_ZERO      = 8'h00;
endpackage

// ---- testbench/phy_base_regs_tb.sv ----
`timescale 1ns/1ps
// ==========================================================
// register space bench: reads queue their expected data, a monitor compares
module phy_base_regs_tb;
    logic       clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0, ce_in = 1'b1;
    logic       bus_reset_in = 1'b0, selfid_done_in = 1'b0, root_won_in = 1'b0;
    logic       phy_cfg_gap_valid_in = 1'b0, cable_power_pin_in = 1'b1, xfer = 1'b0, link_idle_in;
    logic [3:0] addr_in = 4'h0, len = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out;
    logic [5:0] phys_id_in = 6'h00, phy_cfg_gap_in = 6'h00, node_phys_addr_out, gap_count_out, id;
    logic       node_id_valid_out, root_out, cable_power_state_out, root_holdoff_out;
    logic       long_reset_start_out, long_reset_active_out, irq_out;
    logic [2:0] pg;
    logic [7:0] exp_q[$];
    int         fail_count = 0, checks = 0, seed = 32'h4ce4fe6d, i;

    phy_base_regs #(.LRST_CYCLES(8)) i_phy_base_regs (.clk_in, .rst_in, .ce_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .bus_reset_in, .selfid_done_in, .phys_id_in, .root_won_in, .link_idle_in,
        .phy_cfg_gap_valid_in, .phy_cfg_gap_in, .cable_power_pin_in, .node_phys_addr_out, .node_id_valid_out,
        .root_out, .cable_power_state_out, .root_holdoff_out, .gap_count_out, .long_reset_start_out,
        .long_reset_active_out, .irq_out);
    phy_core_model i_phy_core_model (.clk_in, .rst_in, .xfer_in(xfer), .len_in(len), .link_idle_out(link_idle_in));

    // ==========================================================
    // helpers
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        @(posedge clk_in); wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in); rd_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic pulse_reset;
        bus_reset_in <= 1'b1;
        @(posedge clk_in); bus_reset_in <= 1'b0;
        @(posedge clk_in);
    endtask

    // clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // read data stand only in the cycle after the read strobe
    always @(posedge clk_in) begin
        if (rd_q) chk("rdata", rdata_out, exp_q.pop_front());
        rd_q <= rd_in;
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        for (i = 0; i < 16; i++) rd(i[3:0], i == 0 ? 8'h01 : i == 1 ? 8'h3f : i == 2 ? 8'he2 : i == 3 ? 8'h40 : 8'h00);
        wr(4'h1, 8'h85); rd(4'h1, 8'h85);
        wr(4'h0, 8'hff); wr(4'h2, 8'h00); rd(4'h0, 8'h01); rd(4'h2, 8'he2);
        pg = 3'h2 + 3'($unsigned($random(seed)) % 5);
        id = 6'($random(seed));
        wr(4'h7, {pg, 1'b1, id[3:0]}); rd(4'h7, {pg, 1'b0, id[3:0]});
        for (i = 8; i < 16; i++) rd(i[3:0], 8'h00);
        rd(4'h3, 8'h40); rd(4'h1, 8'h85);
        pulse_reset; rd(4'h1, 8'h85); pulse_reset; rd(4'h1, 8'hbf);
        chk("gap", {2'b00, gap_count_out}, 8'h3f);
        chk("holdoff", {7'h0, root_holdoff_out}, 8'h01);
        // a phy configuration load and a register write each break the reset pair
        wr(4'h1, 8'h89); pulse_reset;
        phy_cfg_gap_in <= 6'h07; phy_cfg_gap_valid_in <= 1'b1;
        @(posedge clk_in); phy_cfg_gap_valid_in <= 1'b0;
        pulse_reset; rd(4'h1, 8'h87);
        wr(4'h1, 8'h8a); pulse_reset; rd(4'h1, 8'h8a);
        // self-identification and tree identification
        id = 6'($random(seed));
        phys_id_in <= id; selfid_done_in <= 1'b1; root_won_in <= 1'b1;
        @(posedge clk_in); selfid_done_in <= 1'b0; root_won_in <= 1'b0;
        @(posedge clk_in); rd(4'h0, {id, 2'b11});
        chk("node_addr", {2'b00, node_phys_addr_out}, {2'b00, id});
        pulse_reset; chk("root", {7'h0, root_out}, 8'h00);
        chk("id_valid", {7'h0, node_id_valid_out}, 8'h00);
        wr(4'h7, 8'he0); rd(4'h8, 8'h05); wr(4'h8, 8'h0f); rd(4'h8, 8'h00); wr(4'h9, 8'h08);
        // long reset waits for the transfer in progress
        xfer <= 1'b1; len <= 4'hf;
        @(posedge clk_in); xfer <= 1'b0;
        wr(4'h1, 8'hca);
        repeat (8) begin
            @(posedge clk_in); chk("start_busy", {7'h0, long_reset_start_out}, 8'h00);
        end
        for (i = 0; i < 40 && long_reset_start_out !== 1'b1; i++) @(posedge clk_in);
        if (i == 40) begin fail_count++; test_done; end
        @(posedge clk_in); chk("active", {7'h0, long_reset_active_out}, 8'h01);
        rd(4'h1, 8'h8a);
        for (i = 0; i < 30 && irq_out !== 1'b1; i++) @(posedge clk_in);
        if (i == 30) begin fail_count++; test_done; end
        rd(4'h8, 8'h0c); wr(4'h8, 8'h0f); chk("irq", {7'h0, irq_out}, 8'h00);
        // cable power loss
        cable_power_pin_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk("cps", {7'h0, cable_power_state_out}, 8'h00); rd(4'h8, 8'h02);
        // enable low freezes every register, a write in that time is lost
        ce_in <= 1'b0; wr(4'h1, 8'h00); ce_in <= 1'b1; rd(4'h1, 8'h8a);
        // let the monitor take the last read before the queue is judged
        @(posedge clk_in); chk("pending", 8'(exp_q.size()), 8'h00);
        test_done;
    end
endmodule

// ---- testbench/phy_core_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// far-side traffic: a receive or transmit of a given length keeps the link busy
module phy_core_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // traffic request
    input  wire logic       xfer_in,
    input  wire logic [3:0] len_in,
    // busy indication
    output logic            link_idle_out
);
    logic [3:0] cnt_reg;
    // count down the transfer in progress
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) cnt_reg <= 4'h0;
        else if (xfer_in) cnt_reg <= len_in;
        else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
    assign link_idle_out = (cnt_reg == 4'h0);
endmodule
